// >>> elsr_map.vh
// Register map constants for the express link and slot register bank.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef ELSR_MAP_VH
`define ELSR_MAP_VH

`define ELSR_OFF_LINK       8'hC0
`define ELSR_OFF_SLOT_CAP   8'hC4
`define ELSR_OFF_SLOT_CTRL  8'hC8

`define ELSR_LC_PWR_LO      0
`define ELSR_LC_PWR_HI      1
`define ELSR_LC_RCB         3
`define ELSR_LC_DISABLE     4
`define ELSR_LC_RETRAIN     5
`define ELSR_LC_COMCLK      6
`define ELSR_LC_EXTSYNC     7

`define ELSR_LS_SPEED_LO    16
`define ELSR_LS_WIDTH_LO    20
`define ELSR_LS_TRAIN_ERR   26
`define ELSR_LS_TRAINING    27
`define ELSR_LS_SLOT_CLK    28

`define ELSR_SPEED_RESET    4'h1
`define ELSR_WIDTH_RESET    6'h04
`define ELSR_SLOT_CLK_RESET 1'h1

`define ELSR_SC_CTRL_W      11

`define ELSR_STRAP_WAIT     3'h4

`endif

// >>> elsr_sync.v
// Three-flop synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to hclk.
`timescale 1ns/100ps

module elsr_sync (
  input  wire hclk,     // Bank clock
  input  wire hresetn,  // Async reset, active low
  input  wire din,      // Raw pin level
  output reg  dout      // Filtered level
);

  reg s1;
  reg s2;
  reg s3;

  ////////////////////////////////////////////////////////////////////////////
  // First flop feeds only the second; change counts once stages two and three agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end

endmodule // elsr_sync

// >>> elsr_bank.v
// Express link control/status, slot capability and slot control bank.
// Assumes an AHB-Lite master with single word transfers; status inputs
// come from link training logic on hclk, straps are pins.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "elsr_map.vh"

module elsr_bank (
  input  wire        hclk,          // Bank clock, 100 MHz
  input  wire        hresetn,       // Async reset, active low
  input  wire        hsel,          // Slave select
  input  wire [31:0] haddr,         // Byte address
  input  wire [1:0]  htrans,        // Transfer type
  input  wire        hwrite,        // Write when high
  input  wire [2:0]  hsize,         // Transfer size
  input  wire        hready,        // Bus ready in
  input  wire [31:0] hwdata,        // Write data
  output reg  [31:0] hrdata,        // Read data
  output reg         hreadyout,     // Slave ready
  output reg         hresp,         // Always OKAY
  input  wire        reverse_mode,  // Bridge direction strap, 1 = reverse
  input  wire        hotplug_strap, // Hot-plug enable strap, takes effect only with reverse_mode high
  input  wire [3:0]  link_speed,    // Trained speed from link logic
  input  wire [5:0]  link_width,    // Trained width from link logic
  input  wire        link_train_err,// Training error from link logic
  input  wire        link_training, // Training in progress
  input  wire        link_up,       // Link trained, status valid
  output reg  [1:0]  pwr_state_ctl, // Permitted idle entry levels
  output reg         link_disable,  // Link disable request
  output reg         link_retrain,  // Retrain request
  output reg         common_clock,  // Common clock configuration
  output reg         ext_sync,      // Extended sync
  output reg  [10:0] slot_ctl       // Slot control fields
);

  wire       rev_s;
  wire       hp_s;
  reg        rev_cap;
  reg        hp_cap;
  reg        strap_done;
  reg [2:0]  strap_cnt;
  reg        dp_write;
  reg [7:0]  dp_addr;
  reg [3:0]  speed;
  reg [5:0]  width;
  reg [31:0] next_rdata;
  reg [1:0]  next_pwr;
  reg        next_disable;
  reg        next_retrain;
  reg        next_comclk;
  reg        next_extsync;
  reg [10:0] next_slot;
  wire       hp_on;

  ////////////////////////////////////////////////////////////////////////////
  // Straps come from pins and pass the synchroniser
  elsr_sync u_rev (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (reverse_mode),
    .dout    (rev_s)
  );

  elsr_sync u_hp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (hotplug_strap),
    .dout    (hp_s)
  );

  // Straps captured once after synchroniser settles; later pin moves ignored.
  // The filter shows the pin level only after four edges, so an early capture
  // would latch the reset level of the filter instead of the strap.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt  <= 3'h0;
      rev_cap    <= 1'b0;
      hp_cap     <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == `ELSR_STRAP_WAIT) begin
        rev_cap    <= rev_s;
        hp_cap     <= hp_s;
        strap_done <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 3'h1;
      end
    end
  end

  assign hp_on = hp_cap & rev_cap;

  ////////////////////////////////////////////////////////////////////////////
  // Trained speed and width held; reset values until the link is up
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed <= `ELSR_SPEED_RESET;
      width <= `ELSR_WIDTH_RESET;
    end else if (link_up) begin
      speed <= link_speed;
      width <= link_width;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer decode shared by the write capture and the read register
  function xfer_valid;
    input       sel;
    input [1:0] trans;
    input       rdy;
    begin
      xfer_valid = sel & trans[1] & rdy;
    end
  endfunction

  // Address phase capture; zero wait states so hreadyout stays high
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hready) begin
      dp_write  <= xfer_valid(hsel, htrans, hready) & hwrite;
      dp_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data phase into the next control values. The read mux uses these,
  // so a read right behind a write returns the new word, not the stale one.
  always @* begin
    next_pwr     = pwr_state_ctl;
    next_disable = link_disable;
    next_retrain = link_retrain;
    next_comclk  = common_clock;
    next_extsync = ext_sync;
    next_slot    = slot_ctl;
    if (dp_write && dp_addr == `ELSR_OFF_LINK) begin
      next_pwr     = hwdata[`ELSR_LC_PWR_HI:`ELSR_LC_PWR_LO];
      next_comclk  = hwdata[`ELSR_LC_COMCLK];
      next_extsync = hwdata[`ELSR_LC_EXTSYNC];
      next_disable = hwdata[`ELSR_LC_DISABLE];
      next_retrain = hwdata[`ELSR_LC_RETRAIN];
    end
    if (dp_write && dp_addr == `ELSR_OFF_SLOT_CTRL) begin
      next_slot = hwdata[`ELSR_SC_CTRL_W-1:0];
    end
    // Forward bridge holds both link requests at zero whatever is written
    if (!rev_cap) begin
      next_disable = 1'b0;
      next_retrain = 1'b0;
    end
  end

  // Control registers take the next values; outputs stay flop driven
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_state_ctl <= 2'h0;
      link_disable  <= 1'b0;
      link_retrain  <= 1'b0;
      common_clock  <= 1'b0;
      ext_sync      <= 1'b0;
      slot_ctl      <= 11'h000;
    end else begin
      pwr_state_ctl <= next_pwr;
      link_disable  <= next_disable;
      link_retrain  <= next_retrain;
      common_clock  <= next_comclk;
      ext_sync      <= next_extsync;
      slot_ctl      <= next_slot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, registered at the address phase so data stands in data phase
  always @* begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      `ELSR_OFF_LINK: begin
        next_rdata[`ELSR_LC_PWR_HI:`ELSR_LC_PWR_LO] = next_pwr;
        next_rdata[`ELSR_LC_RCB]      = 1'b0;
        next_rdata[`ELSR_LC_DISABLE]  = next_disable & rev_cap;
        next_rdata[`ELSR_LC_RETRAIN]  = next_retrain & rev_cap;
        next_rdata[`ELSR_LC_COMCLK]   = next_comclk;
        next_rdata[`ELSR_LC_EXTSYNC]  = next_extsync;
        next_rdata[`ELSR_LS_SPEED_LO+3:`ELSR_LS_SPEED_LO] = speed;
        next_rdata[`ELSR_LS_WIDTH_LO+5:`ELSR_LS_WIDTH_LO] = width;
        next_rdata[`ELSR_LS_TRAIN_ERR] = link_train_err;
        next_rdata[`ELSR_LS_TRAINING]  = link_training;
        next_rdata[`ELSR_LS_SLOT_CLK]  = `ELSR_SLOT_CLK_RESET;
      end
      `ELSR_OFF_SLOT_CAP: begin
        next_rdata[0] = hp_on;
        next_rdata[2] = hp_on;
        next_rdata[3] = hp_on;
        next_rdata[4] = hp_on;
        next_rdata[6] = hp_on;
      end
      `ELSR_OFF_SLOT_CTRL: begin
        next_rdata[`ELSR_SC_CTRL_W-1:0] = next_slot;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (xfer_valid(hsel, htrans, hready) && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule // elsr_bank

// >>> elsr_bank_props.sv
// Checker on the ports of the link and slot register bank.
// Assumes straps only move while reset is held.
`timescale 1ns/100ps
module elsr_bank_props (
  input wire        hclk,          // Clock
  input wire        hresetn,       // Reset
  input wire        hsel,          // Select
  input wire [31:0] haddr,         // Address
  input wire [1:0]  htrans,        // Type
  input wire        hwrite,        // Write
  input wire        hready,        // Ready
  input wire [31:0] hwdata,        // Data in
  input wire [31:0] hrdata,        // Data out
  input wire        reverse_mode,  // Direction
  input wire        hotplug_strap, // Hot plug
  input wire [3:0]  link_speed,    // Speed
  input wire        link_up,       // Up
  input wire [1:0]  pwr_state_ctl, // Idle
  input wire        link_disable,  // Disable
  input wire        link_retrain,  // Retrain
  input wire [10:0] slot_ctl,      // Slot
  input wire        common_clock,  // Common clock
  input wire        ext_sync,      // Extended sync
  input wire        hresp          // Response
);
  ////////////////////////////////////////
  // Data-phase flags, so a check sees the address its phase carried
  reg       wp;
  reg       rp;
  reg [7:0] pa;
  wire      hs = reverse_mode & hotplug_strap;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 1'b0;
      rp <= 1'b0;
      pa <= 8'h00;
    end else begin
      wp <= hsel & htrans[1] & hready & hwrite;
      rp <= hsel & htrans[1] & hready & ~hwrite;
      pa <= haddr[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_pwr; wp && pa == 8'hC0 |=> pwr_state_ctl == $past(hwdata[1:0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power control lost");
  property p_rcb; rp && pa == 8'hC0 |-> !hrdata[3]; endproperty
  a_rcb: assert property (p_rcb) else $error("boundary bit set");
  property p_fwd; !reverse_mode |-> !link_disable && !link_retrain; endproperty
  a_fwd: assert property (p_fwd) else $error("forward link bit set");
  // Link up two and three cycles back, so the read must show the speed input from two cycles back
  property p_spd; rp && pa == 8'hC0 && $past(link_up, 2) && $past(link_up, 3)
    |-> hrdata[19:16] == $past(link_speed, 2); endproperty
  a_spd: assert property (p_spd) else $error("speed not shown");
  property p_cap; rp && pa == 8'hC4 |-> hrdata == {25'h0, hs, 1'b0, {3{hs}}, 1'b0, hs};
  endproperty
  a_cap: assert property (p_cap) else $error("slot cap wrong");
  property p_slw; wp && pa == 8'hC8 |=> slot_ctl == $past(hwdata[10:0]); endproperty
  a_slw: assert property (p_slw) else $error("slot ctl lost");
  property p_slr; rp && pa == 8'hC8 |-> hrdata[31:11] == 21'h0; endproperty
  a_slr: assert property (p_slr) else $error("slot spare bits set");
  property p_cfg; wp && pa == 8'hC0
    |=> common_clock == $past(hwdata[6]) && ext_sync == $past(hwdata[7]); endproperty
  a_cfg: assert property (p_cfg) else $error("clock config lost");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  c_slot: cover property (wp && pa == 8'hC8);
  c_cap: cover property (rp && pa == 8'hC4 && hrdata[6]);
  c_rev: cover property (wp && pa == 8'hC0 && reverse_mode);
endmodule // elsr_bank_props
bind elsr_bank elsr_bank_props elsr_bank_props_i (.*);

// >>> elsr_bank_test.sv
// Self-checking bench for the link and slot register bank.
// Sole AHB-Lite master; also drives straps and link status.
`timescale 1ns/100ps
module elsr_bank_test;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         reverse_mode = 1'b0;
  reg         hotplug_strap = 1'b0;
  reg  [3:0]  link_speed = 4'h2;
  reg  [5:0]  link_width = 6'h04;
  reg         link_err = 1'b0;
  reg         link_trn = 1'b0;
  reg         link_up = 1'b0;
  reg         h;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire        hreadyout;
  integer     fails = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     i;
  integer     j;
  ////////////////////////////////////////
  elsr_bank elsr_bank_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .reverse_mode(reverse_mode),
    .hotplug_strap(hotplug_strap), .link_speed(link_speed), .link_width(link_width),
    .link_train_err(link_err), .link_training(link_trn), .link_up(link_up),
    .pwr_state_ctl(), .link_disable(), .link_retrain(), .common_clock(), .ext_sync(),
    .slot_ctl());
  initial forever #5 hclk = ~hclk;
  // One transfer; read data is taken at the closing edge of the data phase
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      check_count = check_count + 1;
      if (rd !== e) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, rd, e);
      end
    end
  endtask
  // Straps change only under reset; wait past the strap capture
  task rst(input r, input s);
    begin
      hresetn <= 1'b0;
      reverse_mode <= r;
      hotplug_strap <= s;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  // Every strap pairing, then live link status and an unmapped word
  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      rst(i[1], i[0]);
      h = i[1] & i[0];
      rdc(8'hC4, {25'h0, h, 1'b0, h, h, h, 1'b0, h});
      rdc(8'hC0, 32'h1041_0000);
      rdc(8'hC8, 32'h0);
      xfer(1'b1, 8'hC8, 32'hFFFF_FFFF);
      rdc(8'hC8, 32'h0000_07FF);
      xfer(1'b1, 8'hC0, 32'hFFFF_FFFF);
      rdc(8'hC0, i[1] ? 32'h1041_00F3 : 32'h1041_00C3);
      for (j = 0; j < 4; j = j + 1) begin
        xfer(1'b1, 8'hC0, j);
        rdc(8'hC0, 32'h1041_0000 | j);
      end
    end
    link_err <= 1'b1;
    link_trn <= 1'b1;
    link_width <= 6'h01;
    link_up <= 1'b1;
    repeat (4) @(posedge hclk);
    // Speed input sat at 2 while the link was down, so earlier reads showed the hold
    rdc(8'hC0, 32'h1C12_0003);
    xfer(1'b1, 8'hCC, 32'hFFFF_FFFF);
    rdc(8'hCC, 32'h0);
    give_verdict;
  end
endmodule // elsr_bank_test
